/* File: hdl/ccr_cfg.svh */
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// ****************************************************************
// Bus address
// ****************************************************************
`define CCR_SLAVE_ADDR      7'h09
`define CCR_BYTE_BITS       4'h8

// ****************************************************************
// Register offsets
// ****************************************************************
`define CCR_OFS_INPUT_SRC   8'h00
`define CCR_OFS_POWER_ON    8'h01
`define CCR_OFS_CHG_CUR     8'h02
`define CCR_OFS_PRE_TERM    8'h03
`define CCR_OFS_BATT_VOLT   8'h04

// ****************************************************************
// Reset values
// ****************************************************************
`define CCR_RST_INPUT_SRC   8'h4F
`define CCR_RST_POWER_ON    8'h04
`define CCR_RST_CHG_CUR     8'h0E
`define CCR_RST_PRE_TERM    8'h4A
`define CCR_RST_BATT_VOLT   8'hA3
`define CCR_UNMAPPED_READ   8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define CCR_HIZ_BIT         7
`define CCR_VINMIN_MSB      6
`define CCR_VINMIN_LSB      3
`define CCR_IINLIM_MSB      2
`define CCR_IINLIM_LSB      0
`define CCR_REGRST_BIT      7
`define CCR_WDRST_BIT       6
`define CCR_PWR_KEEP_MSB    5
`define CCR_CHGDIS_BIT      3
`define CCR_LOCKOUT_MSB     2
`define CCR_LOCKOUT_LSB     0
`define CCR_ICC_MSB         4
`define CCR_ICC_LSB         0
`define CCR_DSCHG_MSB       6
`define CCR_DSCHG_LSB       3
`define CCR_DSCHG_INVALID   4'h0
`define CCR_OTP_BIT         2
`define CCR_IPRE_MSB        1
`define CCR_IPRE_LSB        0
`define CCR_VREG_MSB        7
`define CCR_VREG_LSB        2
`define CCR_PREXIT_BIT      1
`define CCR_RECHG_BIT       0

`endif

/* File: hdl/ccr_pin_sync.sv */
// ****************************************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************************************
module ccr_pin_sync (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level
);

    logic stage1_q;
    logic stage2_q;
    logic stage3_q;
    logic level_q;

    // Bus lines idle high, so every stage starts high
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1_q <= 1'h1;
            stage2_q <= 1'h1;
            stage3_q <= 1'h1;
        end else begin
            stage1_q <= pin;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // Accept a change only once two settled stages agree
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'h1;
        end else if (stage2_q == stage3_q) begin
            level_q <= stage3_q;
        end
    end

    assign level = level_q;

endmodule

/* File: hdl/ccr_pkg.sv */
package ccr_pkg;

    // ****************************************************************
    // Serial slave states
    // ****************************************************************
    typedef enum logic [3:0] {
        CCR_IDLE,
        CCR_ADDR,
        CCR_ADDR_ACK,
        CCR_REG,
        CCR_REG_ACK,
        CCR_WDATA,
        CCR_WDATA_ACK,
        CCR_RDATA,
        CCR_RDATA_ACK
    } ccr_state_type;

endpackage

/* File: hdl/ccr_register_bank.sv */
`include "ccr_cfg.svh"

module ccr_register_bank
    import ccr_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       scl,
    input  wire logic       sda_pin,
    output logic            sda_data,
    output logic            sda_enable,
    output logic            input_high_impedance_enable,
    output logic [3:0]      vin_min_code,
    output logic [2:0]      input_current_limit_code,
    output logic            charge_disable_n,
    output logic [2:0]      battery_lockout_code,
    output logic [4:0]      fast_charge_current_code,
    output logic [3:0]      discharge_limit_code,
    output logic            board_overtemp_disable,
    output logic [1:0]      precharge_current_code,
    output logic [5:0]      regulation_voltage_code,
    output logic            precharge_exit_threshold,
    output logic            recharge_threshold_select,
    output logic            watchdog_restart
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic           rst_meta_q;
    logic           rst_n_q;
    logic           scl_f;
    logic           sda_f;
    logic           scl_prev_q;
    logic           sda_prev_q;
    logic           scl_rise;
    logic           scl_fall;
    logic           bus_start;
    logic           bus_stop;
    ccr_state_type  state_q;
    logic [3:0]     bit_cnt_q;
    logic [7:0]     shift_q;
    logic [7:0]     ptr_q;
    logic           rw_q;
    logic [7:0]     tx_q;
    logic           nack_q;
    logic           sda_enable_q;
    logic           sda_data_q;
    logic           byte_done;
    logic           wr_en;
    logic [7:0]     rd_byte;
    logic [7:0]     input_src_q;
    logic [7:0]     power_on_q;
    logic [7:0]     chg_cur_q;
    logic [7:0]     pre_term_q;
    logic [7:0]     batt_volt_q;
    logic           watchdog_restart_q;

    // ****************************************************************
    // Reset release
    // ****************************************************************

    // Release is synchronous so no flop sees a ragged reset edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'h0;
            rst_n_q    <= 1'h0;
        end else begin
            rst_meta_q <= 1'h1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ****************************************************************
    // Pin conditioning
    // ****************************************************************

    // Both bus lines come from outside the clock domain
    ccr_pin_sync u_scl_sync (
        .clock (clock),
        .rst_n (rst_n_q),
        .pin   (scl),
        .level (scl_f)
    );

    ccr_pin_sync u_sda_sync (
        .clock (clock),
        .rst_n (rst_n_q),
        .pin   (sda_pin),
        .level (sda_f)
    );

    // Previous filtered levels for edge and condition detection
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            scl_prev_q <= 1'h1;
            sda_prev_q <= 1'h1;
        end else begin
            scl_prev_q <= scl_f;
            sda_prev_q <= sda_f;
        end
    end

    // Clock edges, and data edges while the clock stays high
    assign scl_rise  = scl_f & ~scl_prev_q;
    assign scl_fall  = ~scl_f & scl_prev_q;
    assign bus_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
    assign bus_stop  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;
    assign byte_done = scl_fall && (bit_cnt_q == `CCR_BYTE_BITS);

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************

    // Unmapped offsets read as zero rather than aliasing
    function automatic logic [7:0] ccr_read_mux(input logic [7:0] ofs);
        logic [7:0] value;
        value = `CCR_UNMAPPED_READ;
        case (ofs)
            `CCR_OFS_INPUT_SRC: value = input_src_q;
            `CCR_OFS_POWER_ON:  value = power_on_q;
            `CCR_OFS_CHG_CUR:   value = chg_cur_q;
            `CCR_OFS_PRE_TERM:  value = pre_term_q;
            `CCR_OFS_BATT_VOLT: value = batt_volt_q;
            default:            value = `CCR_UNMAPPED_READ;
        endcase
        return value;
    endfunction

    always_comb rd_byte = ccr_read_mux(ptr_q); // Tracks register changes

    // ****************************************************************
    // Serial slave sequencer
    // ****************************************************************

    // Data moves only while the clock is low; start and stop win
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q      <= CCR_IDLE;
            bit_cnt_q    <= 4'h0;
            shift_q      <= 8'h00;
            ptr_q        <= 8'h00;
            rw_q         <= 1'h0;
            tx_q         <= 8'h00;
            nack_q       <= 1'h0;
            sda_enable_q <= 1'h0;
        end else if (bus_start) begin
            state_q      <= CCR_ADDR;
            bit_cnt_q    <= 4'h0;
            sda_enable_q <= 1'h0;
        end else if (bus_stop) begin
            state_q      <= CCR_IDLE;
            sda_enable_q <= 1'h0;
        end else begin
            unique case (state_q)
                CCR_IDLE: begin
                    sda_enable_q <= 1'h0;
                end
                CCR_ADDR, CCR_REG, CCR_WDATA: begin
                    if (scl_rise) begin
                        shift_q   <= {shift_q[6:0], sda_f};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_done) begin
                        if (state_q == CCR_ADDR) begin
                            if (shift_q[7:1] == `CCR_SLAVE_ADDR) begin
                                rw_q         <= shift_q[0];
                                sda_enable_q <= 1'h1;
                                state_q      <= CCR_ADDR_ACK;
                            end else begin
                                state_q      <= CCR_IDLE;
                            end
                        end else if (state_q == CCR_REG) begin
                            ptr_q        <= shift_q;
                            sda_enable_q <= 1'h1;
                            state_q      <= CCR_REG_ACK;
                        end else begin
                            // Pointer steps so multi-byte writes walk on
                            ptr_q        <= ptr_q + 8'h01;
                            sda_enable_q <= 1'h1;
                            state_q      <= CCR_WDATA_ACK;
                        end
                    end
                end
                CCR_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            // First read bit goes out at once
                            sda_enable_q <= ~rd_byte[7];
                            tx_q         <= {rd_byte[6:0], 1'h0};
                            bit_cnt_q    <= 4'h1;
                            state_q      <= CCR_RDATA;
                        end else begin
                            sda_enable_q <= 1'h0;
                            bit_cnt_q    <= 4'h0;
                            state_q      <= CCR_REG;
                        end
                    end
                end
                CCR_REG_ACK, CCR_WDATA_ACK: begin
                    if (scl_fall) begin
                        sda_enable_q <= 1'h0;
                        bit_cnt_q    <= 4'h0;
                        state_q      <= CCR_WDATA;
                    end
                end
                CCR_RDATA: begin
                    if (byte_done) begin
                        sda_enable_q <= 1'h0;
                        ptr_q        <= ptr_q + 8'h01;
                        state_q      <= CCR_RDATA_ACK;
                    end else if (scl_fall) begin
                        sda_enable_q <= ~tx_q[7];
                        tx_q         <= {tx_q[6:0], 1'h0};
                        bit_cnt_q    <= bit_cnt_q + 4'h1;
                    end
                end
                CCR_RDATA_ACK: begin
                    if (scl_rise) begin
                        nack_q <= sda_f;
                    end else if (scl_fall) begin
                        if (nack_q) begin
                            // Master is done; wait for stop or restart
                            state_q      <= CCR_IDLE;
                        end else begin
                            sda_enable_q <= ~rd_byte[7];
                            tx_q         <= {rd_byte[6:0], 1'h0};
                            bit_cnt_q    <= 4'h1;
                            state_q      <= CCR_RDATA;
                        end
                    end
                end
                default: begin
                    state_q      <= CCR_IDLE;
                    sda_enable_q <= 1'h0;
                end
            endcase
        end
    end

    // The pin is only ever pulled low, never driven high
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sda_data_q <= 1'h0;
        end else begin
            sda_data_q <= 1'h0;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************

    // Write lands when the eighth data bit has been clocked in
    assign wr_en = (state_q == CCR_WDATA) && byte_done;

    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            input_src_q <= `CCR_RST_INPUT_SRC;
            power_on_q  <= `CCR_RST_POWER_ON;
            chg_cur_q   <= `CCR_RST_CHG_CUR;
            pre_term_q  <= `CCR_RST_PRE_TERM;
            batt_volt_q <= `CCR_RST_BATT_VOLT;
        end else if (wr_en) begin
            case (ptr_q)
                `CCR_OFS_INPUT_SRC: begin
                    input_src_q <= shift_q;
                end
                `CCR_OFS_POWER_ON: begin
                    if (shift_q[`CCR_REGRST_BIT]) begin
                        // Whole map returns to defaults, itself included
                        input_src_q <= `CCR_RST_INPUT_SRC;
                        power_on_q  <= `CCR_RST_POWER_ON;
                        chg_cur_q   <= `CCR_RST_CHG_CUR;
                        pre_term_q  <= `CCR_RST_PRE_TERM;
                        batt_volt_q <= `CCR_RST_BATT_VOLT;
                    end else begin
                        // Command bits are never stored
                        power_on_q <= {2'h0,
                            shift_q[`CCR_PWR_KEEP_MSB:0]};
                    end
                end
                `CCR_OFS_CHG_CUR: begin
                    chg_cur_q <= shift_q;
                end
                `CCR_OFS_PRE_TERM: begin
                    // Invalid limit code keeps the previous limit
                    if (shift_q[`CCR_DSCHG_MSB:`CCR_DSCHG_LSB]
                        == `CCR_DSCHG_INVALID) begin
                        pre_term_q <= {shift_q[7],
                            pre_term_q[`CCR_DSCHG_MSB:`CCR_DSCHG_LSB],
                            shift_q[`CCR_OTP_BIT:0]};
                    end else begin
                        pre_term_q <= shift_q;
                    end
                end
                `CCR_OFS_BATT_VOLT: begin
                    batt_volt_q <= shift_q;
                end
                default: begin
                    // Writes to unmapped offsets are dropped
                    input_src_q <= input_src_q;
                end
            endcase
        end
    end

    // One-cycle restart pulse toward the watchdog timer
    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            watchdog_restart_q <= 1'h0;
        end else begin
            watchdog_restart_q <= wr_en && (ptr_q == `CCR_OFS_POWER_ON)
                && shift_q[`CCR_WDRST_BIT];
        end
    end

    // ****************************************************************
    // Output fields, straight from register bits
    // ****************************************************************
    assign sda_data                    = sda_data_q;
    assign sda_enable                  = sda_enable_q;
    assign input_high_impedance_enable = input_src_q[`CCR_HIZ_BIT];
    assign vin_min_code                =
        input_src_q[`CCR_VINMIN_MSB:`CCR_VINMIN_LSB];
    assign input_current_limit_code    =
        input_src_q[`CCR_IINLIM_MSB:`CCR_IINLIM_LSB];
    assign charge_disable_n            = power_on_q[`CCR_CHGDIS_BIT];
    assign battery_lockout_code        =
        power_on_q[`CCR_LOCKOUT_MSB:`CCR_LOCKOUT_LSB];
    assign fast_charge_current_code    =
        chg_cur_q[`CCR_ICC_MSB:`CCR_ICC_LSB];
    assign discharge_limit_code        =
        pre_term_q[`CCR_DSCHG_MSB:`CCR_DSCHG_LSB];
    assign board_overtemp_disable      = pre_term_q[`CCR_OTP_BIT];
    assign precharge_current_code      =
        pre_term_q[`CCR_IPRE_MSB:`CCR_IPRE_LSB];
    assign regulation_voltage_code     =
        batt_volt_q[`CCR_VREG_MSB:`CCR_VREG_LSB];
    assign precharge_exit_threshold    = batt_volt_q[`CCR_PREXIT_BIT];
    assign recharge_threshold_select   = batt_volt_q[`CCR_RECHG_BIT];
    assign watchdog_restart            = watchdog_restart_q;

endmodule

/* File: verif/ccr_host_model.sv */
// ****************************************************************
// Serial bus master, drives scl directly, open drain on sda only
// ****************************************************************
module ccr_host_model (
    input  wire logic clock,
    input  wire logic sda_pin,
    output logic      scl,
    output logic      sda_rel
);
    timeunit 1ns;
    timeprecision 1ns;
    // Both lines idle high: scl driven high, sda released to its pull-up
    initial begin
        scl = 1'h1;
        sda_rel = 1'h1;
    end
    // Ten clocks per level so the pin filters see every one
    task automatic hold();
        repeat (10) @(posedge clock);
        #2;
    endtask
    // Start or repeated start, ends with scl low
    task automatic start();
        sda_rel = 1'h1;
        hold();
        scl = 1'h1;
        hold();
        sda_rel = 1'h0;
        hold();
        scl = 1'h0;
        hold();
    endtask
    task automatic stop();
        sda_rel = 1'h0;
        hold();
        scl = 1'h1;
        hold();
        sda_rel = 1'h1;
        hold();
    endtask
    // Data only moves while scl is low; sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        sda_rel = b;
        hold();
        scl = 1'h1;
        hold();
        r = sda_pin;
        hold();
        scl = 1'h0;
        hold();
    endtask
    // MSB first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] tx, input logic ack_tx,
                           output logic [7:0] rx, output logic ack_rx);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(ack_tx, ack_rx);
    endtask
endmodule

/* File: verif/ccr_register_bank_chk.sv */
module ccr_register_bank_chk (
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic       scl,
    input wire logic       sda_data,
    input wire logic       sda_enable,
    input wire logic       watchdog_restart,
    input wire logic       charge_disable_n,
    input wire logic [4:0] fast_charge_current_code,
    input wire logic [3:0] discharge_limit_code,
    input wire logic [5:0] regulation_voltage_code
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Port relations
    // ****************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_drive_only_low: assert property (
        sda_data == 1'h0) else $error("data output driven high");
    a_ack_scl_low: assert property (
        $changed(sda_enable) |-> !scl) else $error("data pull moved, scl high");
    a_ack_held: assert property (
        $rose(sda_enable) |-> sda_enable[*8]) else $error("data pull too short");
    a_wd_one_cycle: assert property (
        watchdog_restart |=> !watchdog_restart) else $error("restart pulse long");
    a_wd_in_ack: assert property (
        watchdog_restart |-> sda_enable && !scl) else $error("restart off ack");
    a_dschg_valid: assert property (
        discharge_limit_code != 4'h0) else $error("discharge code zero");
    a_icc_with_ack: assert property (
        $changed(fast_charge_current_code) |-> sda_enable)
        else $error("charge code moved outside write");
    a_vreg_with_ack: assert property (
        $changed(regulation_voltage_code) |-> sda_enable)
        else $error("regulation code moved outside write");
    a_chgdis_scl_low: assert property (
        $changed(charge_disable_n) |-> !scl)
        else $error("charge disable moved, scl high");
    // Main scenarios reached
    cover property (watchdog_restart);
    cover property ($rose(sda_enable));
    cover property ($changed(regulation_voltage_code));
endmodule

bind ccr_register_bank ccr_register_bank_chk u_chk (
    .clock                    (clock),
    .rst_b                    (rst_b),
    .scl                      (scl),
    .sda_data                 (sda_data),
    .sda_enable               (sda_enable),
    .watchdog_restart         (watchdog_restart),
    .charge_disable_n         (charge_disable_n),
    .fast_charge_current_code (fast_charge_current_code),
    .discharge_limit_code     (discharge_limit_code),
    .regulation_voltage_code  (regulation_voltage_code)
);

/* File: verif/testbench.sv */
`include "ccr_cfg.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'h0;
    logic        rst_b = 1'h0;
    logic        scl, sda_rel, sda_pin, sda_data, sda_enable, wd;
    logic        hiz, chgdis, otp, prex, rech;
    logic [3:0]  vin, dschg;
    logic [2:0]  ilim, lock;
    logic [4:0]  icc;
    logic [1:0]  ipre;
    logic [5:0]  vreg;
    logic [31:0] fields;
    logic [7:0]  wd_count = 8'h00;
    int          n_fail = 0;
    int          check_count = 0;

    // ****************************************************************
    // Clock, wire resolution, parts
    // ****************************************************************
    always #25 clock = ~clock;
    // Open drain with pull-up: low if either side pulls
    assign sda_pin = sda_rel & ~sda_enable;
    assign fields = {hiz, vin, ilim, chgdis, lock, icc, dschg, otp, ipre,
                     vreg, prex, rech};
    always @(posedge clock)
        if (wd === 1'h1) wd_count <= wd_count + 8'h01;

    ccr_host_model host (.clock(clock), .sda_pin(sda_pin), .scl(scl),
                         .sda_rel(sda_rel));
    ccr_register_bank uut (
        .clock(clock), .rst_b(rst_b), .scl(scl), .sda_pin(sda_pin),
        .sda_data(sda_data), .sda_enable(sda_enable),
        .input_high_impedance_enable(hiz), .vin_min_code(vin),
        .input_current_limit_code(ilim), .charge_disable_n(chgdis),
        .battery_lockout_code(lock), .fast_charge_current_code(icc),
        .discharge_limit_code(dschg), .board_overtemp_disable(otp),
        .precharge_current_code(ipre), .regulation_voltage_code(vreg),
        .precharge_exit_threshold(prex), .recharge_threshold_select(rech),
        .watchdog_restart(wd));

    // ****************************************************************
    // Comparisons and bus helpers
    // ****************************************************************
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: byte %h not %h", $time, got, exp);
        end
    endtask
    task automatic check_fields(input logic [31:0] exp);
        check_count++;
        if (fields !== exp) begin
            n_fail++;
            $display("unexpected at %0t: fields %h not %h", $time, fields, exp);
        end
    endtask
    // Field outputs follow the five register images
    function automatic logic [31:0] fexp(input logic [7:0] a, b, c, d, e);
        return {a, b[3:0], c[4:0], d[6:0], e};
    endfunction
    task automatic wr_regs(input logic [7:0] ofs, input logic [7:0] d[$]);
        logic [7:0] rx;
        logic       nk;
        host.start();
        host.byte_io(8'h12, 1'h1, rx, nk);
        check_byte({7'h00, nk}, 8'h00);
        host.byte_io(ofs, 1'h1, rx, nk);
        check_byte({7'h00, nk}, 8'h00);
        foreach (d[i]) begin
            host.byte_io(d[i], 1'h1, rx, nk);
            check_byte({7'h00, nk}, 8'h00);
        end
        host.stop();
    endtask
    // Last byte gets a not-acknowledge before the stop
    task automatic rd_regs(input logic [7:0] ofs, input logic [7:0] e[$]);
        logic [7:0] rx;
        logic       nk;
        host.start();
        host.byte_io(8'h12, 1'h1, rx, nk);
        host.byte_io(ofs, 1'h1, rx, nk);
        host.start();
        host.byte_io(8'h13, 1'h1, rx, nk);
        check_byte({7'h00, nk}, 8'h00);
        foreach (e[i]) begin
            host.byte_io(8'hFF, i == e.size() - 1, rx, nk);
            check_byte(rx, e[i]);
        end
        host.stop();
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_defaults();
        check_fields(fexp(8'h4F, 8'h04, 8'h0E, 8'h4A, 8'hA3));
        rd_regs(8'h00, {8'h4F, 8'h04, 8'h0E, 8'h4A, 8'hA3});
    endtask
    // Burst over all five, zero discharge code refused
    task automatic t_burst();
        wr_regs(8'h00, {8'hB2, 8'h3B, 8'hF5, 8'h85, 8'h5C});
        check_fields(fexp(8'hB2, 8'h3B, 8'hF5, 8'hCD, 8'h5C));
        rd_regs(8'h00, {8'hB2, 8'h3B, 8'hF5, 8'hCD, 8'h5C});
    endtask
    // Run past the last register into unmapped space
    task automatic t_unmapped();
        wr_regs(8'h03, {8'h7B, 8'hA0, 8'h99});
        check_fields(fexp(8'hB2, 8'h3B, 8'hF5, 8'h7B, 8'hA0));
        rd_regs(8'h03, {8'h7B, 8'hA0, 8'h00});
    endtask
    task automatic t_wrong_addr();
        logic [7:0] rx;
        logic       nk;
        host.start();
        host.byte_io(8'h14, 1'h1, rx, nk);
        check_byte({7'h00, nk}, 8'h01);
        host.stop();
        check_fields(fexp(8'hB2, 8'h3B, 8'hF5, 8'h7B, 8'hA0));
    endtask
    task automatic t_watchdog();
        logic [7:0] n0;
        n0 = wd_count;
        wr_regs(8'h01, {8'h45});
        check_byte(wd_count - n0, 8'h01);
        rd_regs(8'h01, {8'h05});
        check_fields(fexp(8'hB2, 8'h05, 8'hF5, 8'h7B, 8'hA0));
    endtask
    task automatic t_reg_reset();
        wr_regs(8'h01, {8'hB0});
        check_fields(fexp(8'h4F, 8'h04, 8'h0E, 8'h4A, 8'hA3));
        rd_regs(8'h00, {8'h4F, 8'h04, 8'h0E, 8'h4A, 8'hA3});
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Lines idle high through reset so the pin filters start clean
    initial begin
        repeat (12) @(posedge clock);
        #2 rst_b = 1'h1;
        repeat (10) @(posedge clock);
        t_defaults();
        t_burst();
        t_unmapped();
        t_wrong_addr();
        t_watchdog();
        t_reg_reset();
        give_verdict();
    end
endmodule
